/* File: rtl/mpsc_top.sv */
// Mute patch memory, solo-in-place and display control with APB access
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ns
module mpsc_top #(
    parameter int N_CH      = mpsc_pkg::N_CH_DEF,
    parameter int REP_DELAY = mpsc_pkg::REP_DELAY_CYC,
    parameter int REP_RATE  = mpsc_pkg::REP_RATE_CYC,
    parameter int BLINK     = mpsc_pkg::BLINK_CYC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire mpsc_pkg::mpsc_keys_t key_in,
    input  wire logic [N_CH-1:0]      mute_sw,
    output logic      [N_CH-1:0]      mute_out,
    output logic      [N_CH-1:0]      safe_led,
    output logic                      preview_led,
    output logic                      store_led,
    output logic                      solo_led,
    output logic                      safe_edit_led,
    output mpsc_pkg::mpsc_disp_t      disp
);
    import mpsc_pkg::*;

    generate
        if (N_CH < 1 || N_CH > 32 || REP_DELAY < 2 || REP_RATE < 2 || BLINK < 2) begin : g_bad
            $error("mpsc_top: unsupported parameter value");
        end
    endgenerate

    mpsc_keys_t  k_s1, kh, k_prev, kp;
    logic [N_CH-1:0] m_s1, m_s2, m_prev, mpr;
    mpsc_state_t state_q;
    logic [N_CH-1:0] mute_q, saved_q, last_q, msafe_q, group_q, ssafe_q;
    logic [N_CH-1:0] rec_img_q, keep, patch_rd;
    logic [N_CH-1:0] mem [N_PATCH];
    logic [7:0]  sel_q, last_rec_q, ser_q;
    logic [6:0]  wr_idx_q;
    logic        solo_en_q, auto_inc_q, ls_on_q, rec_valid_q, match;
    logic        any_key, step_up, step_dn, scroll_ok;
    logic [31:0] rep_cnt_q, blink_cnt_q;
    logic        rep_fast_q, blink_q;
    logic        wr_en, rd_en, hit;
    logic [31:0] rdata;

    // Wrapping scroll through 0..127 then the all entry
    function automatic logic [7:0] next_sel(input logic [7:0] s, input logic up);
        if (up) begin
            next_sel = (s == SEL_ALL) ? 8'h00 : s + 8'h01;
        end else begin
            next_sel = (s == 8'h00) ? SEL_ALL : s - 8'h01;
        end
    endfunction : next_sel

    // Two-flop synchronisers for panel keys and switches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            k_s1   <= '0;
            kh     <= '0;
            k_prev <= '0;
            m_s1   <= '0;
            m_s2   <= '0;
            m_prev <= '0;
        end else begin
            k_s1   <= key_in;
            kh     <= k_s1;
            k_prev <= kh;
            m_s1   <= mute_sw;
            m_s2   <= m_s1;
            m_prev <= m_s2;
        end
    end

    // Press edges; any press other than store cancels an armed overwrite
    assign kp      = kh & ~k_prev;
    assign mpr     = m_s2 & ~m_prev;
    assign any_key = (|kp) || (|mpr);
    assign keep    = msafe_q | group_q;
    assign patch_rd = (sel_q == SEL_ALL) ? '0 : mem[sel_q[6:0]];
    assign match   = rec_valid_q && (((mute_q ^ rec_img_q) & ~keep) == '0);

    // Auto-repeat timer for held up/down keys
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rep_cnt_q  <= '0;
            rep_fast_q <= 1'b0;
        end else if (!(kh.up ^ kh.down) || kp.up || kp.down) begin
            rep_cnt_q  <= '0;
            rep_fast_q <= 1'b0;
        end else if (rep_cnt_q == 32'(rep_fast_q ? REP_RATE - 1 : REP_DELAY - 1)) begin
            rep_cnt_q  <= '0;
            rep_fast_q <= 1'b1;
        end else begin
            rep_cnt_q  <= rep_cnt_q + 32'h1;
        end
    end

    // A step on the press itself, then at the repeat rate
    always_comb begin
        logic tick;
        tick    = 1'b0;
        tick    = (kh.up ^ kh.down) && !kp.up && !kp.down
                  && rep_cnt_q == 32'(rep_fast_q ? REP_RATE - 1 : REP_DELAY - 1);
        step_up = kp.up || (tick && kh.up);
        step_dn = kp.down || (tick && kh.down);
    end

    // Shift turns up/down into mode keys, not scrolling
    assign scroll_ok = !kh.shift && (state_q == S_NORMAL || state_q == S_PREVIEW);

    // Blink phase shared by every flashing indicator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q == 32'(BLINK - 1)) begin
            blink_cnt_q <= '0;
            blink_q     <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // Mode sequencing and console mute state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_NORMAL;
            mute_q  <= '0;
            saved_q <= '0;
            last_q  <= '0;
            ls_on_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_NORMAL: begin
                    mute_q <= mute_q ^ mpr;
                    if (kp.solo_in_place_key) begin
                        saved_q <= mute_q;
                        if (!solo_en_q) begin
                            state_q <= S_SOLO_OFF;
                        end else if (kh.shift) begin
                            mute_q  <= (mute_q & ssafe_q) | (last_q & ~ssafe_q);
                            ls_on_q <= 1'b1;
                            state_q <= S_LAST_SOLO;
                        end else begin
                            mute_q  <= mute_q;
                            state_q <= S_SOLO_ARMED;
                        end
                    end else if (kh.shift && kp.up) begin
                        state_q <= S_CONSOLE;
                    end else if (kh.shift && kp.preview) begin
                        state_q <= S_SERIAL;
                    end else if (kp.preview) begin
                        state_q <= S_PREVIEW;
                    end else if (kp.recall && !kh.shift && sel_q != SEL_ALL) begin
                        mute_q <= (mute_q & keep) | (patch_rd & ~keep);
                    end else if (kp.store && sel_q == SEL_ALL) begin
                        state_q <= S_ALL_ARMED;
                    end else if (kp.clear_all || kp.set_all) begin
                        ls_on_q <= kp.set_all;
                        state_q <= S_PROMPT;
                    end
                end
                S_PREVIEW: begin
                    mute_q <= mute_q ^ mpr;
                    if (kp.preview) begin
                        state_q <= S_NORMAL;
                    end
                end
                S_ALL_ARMED: begin
                    if (kp.store) begin
                        state_q <= S_ALL_WRITE;
                    end else if (any_key) begin
                        state_q <= S_NORMAL;
                    end
                end
                S_ALL_WRITE: begin
                    if (wr_idx_q == 7'h7F) begin
                        state_q <= S_NORMAL;
                    end
                end
                S_PROMPT: begin
                    if (kp.store) begin
                        mute_q  <= ls_on_q ? '1 : '0;
                        ls_on_q <= 1'b0;
                        state_q <= S_NORMAL;
                    end else if (any_key) begin
                        ls_on_q <= 1'b0;
                        state_q <= S_NORMAL;
                    end
                end
                S_SOLO_OFF: begin
                    if (!kh.solo_in_place_key) begin
                        state_q <= S_NORMAL;
                    end
                end
                S_SOLO_ARMED: begin
                    if (!kh.solo_in_place_key) begin
                        state_q <= S_NORMAL;
                    end else if (kp.safe_edit) begin
                        state_q <= S_SAFE_EDIT;
                    end else if (|mpr) begin
                        mute_q  <= (mute_q & ssafe_q) | (~ssafe_q & ~mpr);
                        state_q <= S_SOLO;
                    end
                end
                S_SOLO: begin
                    if (!kh.solo_in_place_key) begin
                        mute_q  <= saved_q;
                        last_q  <= mute_q;
                        state_q <= S_NORMAL;
                    end else begin
                        mute_q <= mute_q ^ mpr;
                    end
                end
                S_SAFE_EDIT: begin
                    if (!kh.solo_in_place_key) begin
                        state_q <= S_NORMAL;
                    end else if (!kh.safe_edit) begin
                        state_q <= S_SOLO_ARMED;
                    end
                end
                S_LAST_SOLO: begin
                    if (!kh.shift) begin
                        mute_q  <= saved_q;
                        ls_on_q <= 1'b0;
                        state_q <= S_NORMAL;
                    end else if (kp.solo_in_place_key) begin
                        ls_on_q <= ~ls_on_q;
                        mute_q  <= ls_on_q ? saved_q
                                   : (saved_q & ssafe_q) | (last_q & ~ssafe_q);
                    end
                end
                S_CONSOLE: begin
                    if (!(kh.shift && kh.up)) begin
                        state_q <= S_NORMAL;
                    end
                end
                S_SERIAL: begin
                    if (!(kh.shift && kh.preview)) begin
                        state_q <= S_NORMAL;
                    end
                end
            endcase
        end
    end

    // Selected patch number: scrolling and auto increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 8'h00;
        end else if (scroll_ok && step_up) begin
            sel_q <= next_sel(sel_q, 1'b1);
        end else if (scroll_ok && step_dn) begin
            sel_q <= next_sel(sel_q, 1'b0);
        end else if (state_q == S_NORMAL && !kh.shift && !kp.solo_in_place_key && !kp.preview
                     && kp.recall && auto_inc_q && sel_q != SEL_ALL) begin
            sel_q <= next_sel(sel_q, 1'b1);
        end
    end

    // Last recalled patch and its applied image for the patch dot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_rec_q  <= 8'h00;
            rec_img_q   <= '0;
            rec_valid_q <= 1'b0;
        end else if (state_q == S_NORMAL && !kp.solo_in_place_key && !kh.shift
                     && !kp.preview && kp.recall && sel_q != SEL_ALL) begin
            last_rec_q  <= sel_q;
            rec_img_q   <= patch_rd;
            rec_valid_q <= 1'b1;
        end
    end

    // Overwrite walk index for the all entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_idx_q <= 7'h00;
        end else if (state_q == S_ALL_WRITE) begin
            wr_idx_q <= wr_idx_q + 7'h01;
        end else begin
            wr_idx_q <= 7'h00;
        end
    end

    // Patch memory; contents are undefined until stored
    always_ff @(posedge pclk) begin
        if (state_q == S_ALL_WRITE) begin
            mem[wr_idx_q] <= mute_q;
        end else if (state_q == S_NORMAL && kp.store && sel_q != SEL_ALL
                     && !kp.solo_in_place_key && !kh.shift) begin
            mem[sel_q[6:0]] <= mute_q;
        end
    end

    // APB decode; zero wait states, read data captured at setup
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite && hit;
    assign rd_en   = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !hit;
    assign hit     = paddr == A_CTRL || paddr == A_STATUS || paddr == A_MSAFE
                     || paddr == A_GROUP || paddr == A_SSAFE || paddr == A_MUTES
                     || paddr == A_SERIAL;

    // Read mux; narrow registers zero-extend
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (paddr)
            A_CTRL: begin
                rdata[CTRL_SOLO_EN]  = solo_en_q;
                rdata[CTRL_AUTO_INC] = auto_inc_q;
            end
            A_STATUS: begin
                rdata[ST_SEL_LSB +: 8]   = sel_q;
                rdata[ST_LAST_LSB +: 8]  = last_rec_q;
                rdata[ST_STATE_LSB +: 4] = state_q;
                rdata[ST_MATCH]          = match;
            end
            A_MSAFE:  rdata[N_CH-1:0] = msafe_q;
            A_GROUP:  rdata[N_CH-1:0] = group_q;
            A_SSAFE:  rdata[N_CH-1:0] = ssafe_q;
            A_MUTES:  rdata[N_CH-1:0] = mute_q;
            A_SERIAL: rdata[7:0]      = ser_q;
            default:  rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rdata;
        end
    end

    // Settings: bus writes first, panel toggles win the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            solo_en_q  <= RST_SOLO_EN;
            auto_inc_q <= RST_AUTO_INC;
            msafe_q    <= '0;
            group_q    <= '0;
            ssafe_q    <= '0;
            ser_q      <= RST_SER;
        end else begin
            if (wr_en && paddr == A_CTRL) begin
                solo_en_q  <= pwdata[CTRL_SOLO_EN];
                auto_inc_q <= pwdata[CTRL_AUTO_INC];
            end
            if (wr_en && paddr == A_MSAFE) begin
                msafe_q <= pwdata[N_CH-1:0];
            end
            if (wr_en && paddr == A_GROUP) begin
                group_q <= pwdata[N_CH-1:0];
            end
            // Solo safes live apart from mute safes; software archives them
            if (wr_en && paddr == A_SSAFE) begin
                ssafe_q <= pwdata[N_CH-1:0];
            end
            if (wr_en && paddr == A_SERIAL && pwdata[7:0] <= SER_MAX) begin
                ser_q <= pwdata[7:0];
            end
            if (state_q == S_SAFE_EDIT && kh.safe_edit && kh.solo_in_place_key) begin
                ssafe_q <= ((wr_en && paddr == A_SSAFE) ? pwdata[N_CH-1:0] : ssafe_q) ^ mpr;
            end
            if (state_q == S_CONSOLE && kh.shift && kh.up && kp.recall) begin
                solo_en_q <= ~((wr_en && paddr == A_CTRL) ? pwdata[CTRL_SOLO_EN] : solo_en_q);
            end
            if (state_q == S_SERIAL && kh.shift && kh.preview && (kp.up || kp.down)) begin
                ser_q <= kp.up ? ((ser_q == SER_MAX) ? 8'h00 : ser_q + 8'h01)
                               : ((ser_q == 8'h00) ? SER_MAX : ser_q - 8'h01);
            end
        end
    end

    // Display and indicator registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp          <= '{DK_PATCH, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
            safe_led      <= '0;
            preview_led   <= 1'b0;
            store_led     <= 1'b0;
            solo_led      <= 1'b0;
            safe_edit_led <= 1'b0;
            mute_out      <= '0;
        end else begin
            mute_out      <= mute_q;
            preview_led   <= state_q == S_PREVIEW && blink_q;
            store_led     <= state_q == S_ALL_ARMED && blink_q;
            safe_edit_led <= state_q == S_SAFE_EDIT && blink_q;
            solo_led      <= ((state_q == S_SOLO_ARMED || state_q == S_SAFE_EDIT) && blink_q)
                             || state_q == S_SOLO || state_q == S_LAST_SOLO;
            unique case (state_q)
                S_PREVIEW: safe_led <= patch_rd;
                S_SOLO_ARMED, S_SOLO, S_SAFE_EDIT, S_LAST_SOLO: safe_led <= ssafe_q;
                default: safe_led <= msafe_q;
            endcase
            disp <= '{(sel_q == SEL_ALL) ? DK_ALL : DK_PATCH, sel_q, 1'b0,
                      (sel_q != last_rec_q) ? blink_q : match, 1'b0, 1'b0, 1'b0};
            unique case (state_q)
                S_ALL_ARMED: disp <= '{DK_ALL, SEL_ALL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
                S_ALL_WRITE: disp <= '{DK_PATCH, {1'b0, wr_idx_q}, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
                S_PROMPT: disp <= '{ls_on_q ? DK_SET : DK_CLEAR, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
                S_SOLO_OFF: disp <= '{DK_OFF, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
                S_CONSOLE: disp <= '{DK_MODE, MODE_SOLO, 1'b0, 1'b0, 1'b1, 1'b0, solo_en_q};
                S_SERIAL: disp <= '{(ser_q == 8'h00) ? DK_OFF : DK_SERIAL, ser_q,
                                    1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
                default: ;
            endcase
        end
    end
endmodule : mpsc_top

/* File: include/mpsc_pkg.sv */
// Constants and types for the mute patch and solo controller
// Behaviour
// - 128 patch memories plus special all entry
// - Up/down step patch; held keys auto-repeat
// - Store copies console mutes into selected patch
// - Preview shows patch mutes; preview light flashes
// - Preview keeps mutes; switches work; preview exits
// - Recall loads patch except safe/group channels
// - All entry store writes every patch
// - First store on all only arms, flashing
// - Second store confirms; other key cancels
// - Display steps through patches while writing
// - Clear/set all flashes matching prompt
// - Console mode: mode dot, code, equals sign if solo on
// - Serial channel: channel dot, 1-16 or off
// - Solo held arms, flashes, shows solo safes
// - Mute press solos it, keeps solo safes
// - Further presses toggle mutes while soloing
// - Solo release restores saved mutes
// - Shift+solo toggles last solo and mix
// - Solo+safe edit toggles solo-safe flags only
// - Safe edit release re-arms; both release exits
// - Solo safes kept apart, software-archivable
// - Shift+up shows solo enable; recall toggles
// - Disabled solo shows off, mutes untouched
// - Patch dot: match lit, changed off, differ flash
// - Auto increment advances patch after recall
package mpsc_pkg;
    localparam int N_CH_DEF  = 32;
    localparam int N_PATCH   = 128;
    localparam logic [7:0] SEL_ALL    = 8'h80;
    localparam logic [7:0] SER_MAX    = 8'h10;
    localparam logic [7:0] MODE_SOLO  = 8'h50;
    // Register byte offsets
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_STATUS   = 8'h04;
    localparam logic [7:0] A_MSAFE    = 8'h08;
    localparam logic [7:0] A_GROUP    = 8'h0C;
    localparam logic [7:0] A_SSAFE    = 8'h10;
    localparam logic [7:0] A_MUTES    = 8'h14;
    localparam logic [7:0] A_SERIAL   = 8'h18;
    // Control fields and reset values
    localparam int CTRL_SOLO_EN  = 0;
    localparam int CTRL_AUTO_INC = 1;
    localparam logic RST_SOLO_EN  = 1'b1;
    localparam logic RST_AUTO_INC = 1'b0;
    localparam logic [7:0] RST_SER = 8'h01;
    // Status fields
    localparam int ST_SEL_LSB   = 0;
    localparam int ST_LAST_LSB  = 8;
    localparam int ST_STATE_LSB = 16;
    localparam int ST_MATCH     = 20;
    // Timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int REP_DELAY_MS  = 500;
    localparam int REP_RATE_MS   = 80;
    localparam int BLINK_MS      = 250;
    localparam int REP_DELAY_CYC = REP_DELAY_MS * (CLK_HZ / 1000);
    localparam int REP_RATE_CYC  = REP_RATE_MS * (CLK_HZ / 1000);
    localparam int BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic up;
        logic down;
        logic store;
        logic recall;
        logic preview;
        logic shift;
        logic solo_in_place_key;
        logic safe_edit;
        logic clear_all;
        logic set_all;
    } mpsc_keys_t;

    typedef enum logic [3:0] {
        S_NORMAL, S_PREVIEW, S_ALL_ARMED, S_ALL_WRITE, S_PROMPT,
        S_SOLO_ARMED, S_SOLO, S_SAFE_EDIT, S_LAST_SOLO, S_SOLO_OFF,
        S_CONSOLE, S_SERIAL
    } mpsc_state_t;

    typedef enum logic [2:0] {
        DK_PATCH, DK_ALL, DK_CLEAR, DK_SET, DK_MODE, DK_SERIAL, DK_OFF
    } mpsc_dkind_t;

    typedef struct packed {
        mpsc_dkind_t kind;
        logic [7:0]  value;
        logic        flash;
        logic        patch_dot;
        logic        mode_dot;
        logic        chan_dot;
        logic        equals;
    } mpsc_disp_t;
endpackage : mpsc_pkg

/* File: testbench/mpsc_assertions.sv */
// Port checks for the mute patch and solo controller
`timescale 1ns/1ns
module mpsc_assertions #(parameter int N_CH = 32) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [N_CH-1:0]      mute_out,
    input wire mpsc_pkg::mpsc_disp_t disp
);
    import mpsc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Prompt steps: while a warning is shown it must flash in the same cycle
    sequence s_prompt;
        disp.kind inside {DK_CLEAR, DK_SET};
    endsequence
    sequence s_flash;
        disp.flash;
    endsequence
    // Solo refused: off shown on two edges running
    sequence s_off2;
        (disp.kind == DK_OFF && !disp.chan_dot) ##1 (disp.kind == DK_OFF && !disp.chan_dot);
    endsequence
    ready_high_a: assert property (psel |-> pready) else $error("pready low");
    bad_addr_a: assert property (psel && penable && !pwrite && paddr > 8'h18 |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    good_addr_a: assert property (psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    patch_range_a: assert property (disp.kind == DK_PATCH |-> disp.value <= 8'h7F) else $error("patch out of range");
    prompt_flash_a: assert property (s_prompt |-> s_flash) else $error("prompt not flashing");
    mode_view_a: assert property (disp.kind == DK_MODE |-> disp.mode_dot && disp.value == MODE_SOLO)
        else $error("console mode display wrong");
    serial_view_a: assert property (disp.kind == DK_SERIAL |-> disp.chan_dot && disp.value inside {[8'h01:8'h10]})
        else $error("serial display wrong");
    solo_off_a: assert property (s_off2 |-> $stable(mute_out)) else $error("mutes moved with solo off");
endmodule : mpsc_assertions

/* File: testbench/mpsc_panel.sv */
// Front panel model: key and channel mute switch levels
`timescale 1ns/1ns
module mpsc_panel #(parameter int N_CH = 32) (
    input  wire logic [9:0]      keys_req,
    input  wire logic            pclk,
    input  wire logic [N_CH-1:0] sw_req,
    output mpsc_pkg::mpsc_keys_t key_in,
    output logic      [N_CH-1:0] mute_sw
);
    import mpsc_pkg::*;
    // Levels move just after the edge, like a clean switch
    always @(posedge pclk) begin
        key_in <= mpsc_keys_t'(keys_req);
        mute_sw <= sw_req;
    end
endmodule : mpsc_panel

/* File: testbench/tb_top.sv */
// Self-checking bench for the mute patch and solo controller
`timescale 1ns/1ns
module tb_top;
    import mpsc_pkg::*;
    localparam int N_CH = 32;
    localparam logic [9:0] K_UP = 10'h200, K_DN = 10'h100, K_ST = 10'h080, K_RC = 10'h040;
    localparam logic [9:0] K_PV = 10'h020, K_SH = 10'h010, K_SO = 10'h008, K_CL = 10'h002, K_SET = 10'h001;
    logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [7:0]      paddr = '0;
    logic [31:0]     pwdata = '0, prdata, rd, m, ss, keep, lst;
    logic [9:0]      kr = '0;
    logic [N_CH-1:0] swr = '0, mute_out, safe_led, mute_sw;
    logic [31:0]     pm [N_PATCH];
    mpsc_keys_t      key_in;
    mpsc_disp_t      disp;
    int              n_mismatch = 0, n_tests = 0, seed = 81423, k;
    mpsc_top #(.N_CH(N_CH), .REP_DELAY(40), .REP_RATE(20), .BLINK(4)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .key_in(key_in), .mute_sw(mute_sw), .mute_out(mute_out),
        .safe_led(safe_led), .preview_led(), .store_led(), .solo_led(), .safe_edit_led(), .disp(disp));
    mpsc_panel #(.N_CH(N_CH)) u_panel (.pclk(pclk), .keys_req(kr), .sw_req(swr), .key_in(key_in), .mute_sw(mute_sw));
    // Free-running 50 MHz clock
    initial forever #10 pclk = ~pclk;
    task automatic report_and_stop;
        $display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Key levels settle through the input synchronisers
    task automatic keys(input logic [9:0] v);
        @(posedge pclk);
        kr <= v;
        repeat (8) @(posedge pclk);
    endtask : keys
    task automatic tap(input logic [9:0] v);
        keys(v);
        keys(10'h000);
    endtask : tap
    task automatic press(input int c);
        @(posedge pclk);
        swr <= 32'h1 << c;
        repeat (8) @(posedge pclk);
        swr <= '0;
        repeat (8) @(posedge pclk);
    endtask : press
    // Main sequence against the reference model
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, A_CTRL, 0); chk(rd, 32'h1);
        apb(0, 8'h40, 0); chk({rd[30:0], er}, 32'h1);
        keep = $random(seed);
        ss = $random(seed);
        apb(1, A_MSAFE, keep & 32'h0000FFFF);
        apb(1, A_GROUP, keep & 32'hFFFF0000);
        apb(1, A_SSAFE, ss);
        apb(0, A_SSAFE, 0); chk(rd, ss);
        tap(K_SET); chk(32'({disp.flash, disp.kind}), {28'h0, 1'b1, DK_SET});
        tap(K_ST); m = '1; chk(mute_out, m);
        tap(K_DN); apb(0, A_STATUS, 0); chk(rd[7:0], SEL_ALL);
        tap(K_ST); chk(32'({disp.flash, disp.kind}), {28'h0, 1'b1, DK_ALL});
        tap(K_ST); repeat (150) @(posedge pclk);
        for (int i = 0; i < N_PATCH; i++) pm[i] = m;
        tap(K_CL); tap(K_ST); m = '0; chk(mute_out, m);
        tap(K_UP); apb(0, A_STATUS, 0); chk(rd[7:0], 8'h00);
        keys(K_PV); chk(safe_led, pm[0]); chk(mute_out, m);
        keys(0); tap(K_PV); tap(K_RC); m = (m & keep) | (pm[0] & ~keep); chk(mute_out, m);
        keys(K_SO); chk(safe_led, ss); chk(mute_out, m);
        k = $random(seed) & 31;
        press(k); chk(mute_out, (m & ss) | (~ss & ~(32'h1 << k)));
        press(k); lst = ((m & ss) | (~ss & ~(32'h1 << k))) ^ (32'h1 << k); chk(mute_out, lst);
        keys(0); chk(mute_out, m);
        apb(1, A_CTRL, 0); keys(K_SO); chk(32'(disp.kind), 32'(DK_OFF)); chk(mute_out, m);
        keys(0); keys(K_SH | K_UP); chk(32'({disp.equals, disp.kind}), 32'(DK_MODE));
        keys(K_SH | K_UP | K_RC); keys(K_SH | K_UP); chk(32'(disp.equals), 32'h1);
        keys(0); apb(0, A_CTRL, 0); chk(rd, 32'h1);
        keys(K_SH | K_SO); chk(mute_out, (m & ss) | (lst & ~ss)); keys(0); chk(mute_out, m);
        keys(K_UP); repeat (62) @(posedge pclk);
        keys(0); apb(0, A_STATUS, 0); chk(rd[7:0], 8'h03);
        tap(K_ST); keys(K_PV); chk(safe_led, m); keys(0); tap(K_PV);
        keys(K_SH | K_PV); chk(32'({disp.chan_dot, disp.value}), 32'h101); keys(0);
        report_and_stop();
    end
    // Watchdog for a hung handshake
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_top
bind mpsc_top mpsc_assertions #(.N_CH(N_CH)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mute_out(mute_out), .disp(disp));
